// ===== dv/parallel_io_ports_p0_p2_tb.sv
// Self-checking bench for the parallel ports block
`timescale 1ns/10ps
module parallel_io_ports_p0_p2_tb;
  import pio_pkg::*;
  logic clk_sys, rst_n, clk_en, cpu_rd, cpu_wr, cpu_hit, sel, dual, stop;
  logic [5:0] cpu_addr;
  logic [7:0] cpu_wdata, cpu_rdata, p0_in, p0_ext;
  logic [4:0] p1_in, p1_ext;
  logic [2:0] p2_in, p2_ext;
  pio_p0_drv_t p0_drv;
  pio_p1_drv_t p1_drv;
  pio_p2_drv_t p2_drv;
  pio_evt_t pin_evt;
  int err_total, num_checks;

  pio_ports u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_hit(cpu_hit),
    .shared_pin_interrupt_select(sel), .dual_clock_mode(dual),
    .stop_mode(stop), .p0_in(p0_in), .p0_drv(p0_drv), .p1_in(p1_in),
    .p1_drv(p1_drv), .p2_in(p2_in), .p2_drv(p2_drv), .pin_evt(pin_evt));
  pio_pins_model u_pins (.p0_drv(p0_drv), .p1_drv(p1_drv),
    .p2_drv(p2_drv), .p0_ext(p0_ext), .p1_ext(p1_ext), .p2_ext(p2_ext),
    .p0_pin(p0_in), .p1_pin(p1_in), .p2_pin(p2_in));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task conclude;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge clk_sys);
    cpu_wr = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask : wr

  task rd_chk(input logic [5:0] a, input logic [7:0] exp, input logic h);
    @(negedge clk_sys);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge clk_sys);
    cpu_rd = 1'b0;
    chk(cpu_rdata, exp, "read data");
    chk({7'h00, cpu_hit}, {7'h00, h}, "hit");
  endtask : rd_chk

  task wait_evt(input int b);
    int i;
    for (i = 0; i < 8; i++) begin
      @(negedge clk_sys);
      if (pin_evt[b] === 1'b1) break;
    end
    num_checks++;
    if (i == 8) begin
      err_total++;
      $display("mismatch %0t pin event missing", $time);
      conclude();
    end
  endtask : wait_evt

  initial begin
    rst_n = 1'b0;
    cpu_rd = 1'b0;
    cpu_wr = 1'b0;
    cpu_addr = 6'h00;
    cpu_wdata = 8'h00;
    {sel, dual, stop} = 3'h0;
    clk_en = 1'b1;
    p0_ext = 8'hC3;
    p1_ext = 5'h1F;
    p2_ext = 3'h7;
    err_total = 0;
    num_checks = 0;
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    for (int n = 0; n < 6; n++) begin
      @(negedge clk_sys);
      chk({5'h00, pin_evt}, 8'h00, "event after reset");
    end
    rd_chk(PIO_OFS_P0_LATCH, 8'hFF, 1'b1);
    rd_chk(PIO_OFS_P0_DRIVE, 8'h00, 1'b1);
    rd_chk(PIO_OFS_P1_LATCH, 8'h00, 1'b1);
    rd_chk(PIO_OFS_P1_DIR, 8'h00, 1'b1);
    rd_chk(PIO_OFS_P2_LATCH, 8'h07, 1'b1);
    wr(PIO_OFS_P0_LATCH, 8'h5A);
    wr(PIO_OFS_P0_DRIVE, 8'hF0);
    chk(p0_drv.o, 8'h5A, "p0 out");
    chk(p0_drv.oe, 8'hF5, "p0 enable");
    rd_chk(PIO_OFS_P0_LATCH, 8'h5A, 1'b1);
    rd_chk(PIO_OFS_P0_PINS, 8'h52, 1'b1);
    wr(PIO_OFS_P0_LATCH, 8'hFF);
    wr(PIO_OFS_P0_DRIVE, 8'h00);
    rd_chk(PIO_OFS_P0_PINS, 8'hC3, 1'b1);
    wr(PIO_OFS_P1_LATCH, 8'h1F);
    wr(PIO_OFS_P1_DIR, 8'h05);
    chk({3'h0, p1_drv.oe}, 8'h05, "p1 enable");
    rd_chk(PIO_OFS_P1_DIR, 8'h05, 1'b1);
    clk_en = 1'b0;
    wr(PIO_OFS_P1_LATCH, 8'h00);
    clk_en = 1'b1;
    rd_chk(PIO_OFS_P1_LATCH, 8'h1F, 1'b1);
    chk({3'h0, p1_drv.o}, 8'h1F, "p1 out");
    p1_ext = 5'h1D;
    wait_evt(1);
    sel = 1'b1;
    p1_ext = 5'h1C;
    wait_evt(2);
    chk({3'h0, p1_drv.oe}, 8'h04, "p1 select");
    wr(PIO_OFS_P2_LATCH, 8'hFA);
    chk({5'h00, p2_drv.oe}, 8'h05, "p2 enable");
    chk({5'h00, p2_drv.o}, 8'h02, "p2 out");
    rd_chk(PIO_OFS_P2_LATCH, 8'h02, 1'b1);
    rd_chk(PIO_OFS_P2_PINS, 8'h02, 1'b1);
    dual = 1'b1;
    stop = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk({5'h00, p2_drv.oe}, 8'h00, "p2 float");
    p2_ext = 3'h6;
    wait_evt(0);
    rd_chk(PIO_AREA_LAST, 8'h00, 1'b0);
    conclude();
  end
endmodule : parallel_io_ports_p0_p2_tb

// ===== dv/pio_pins_model.sv
// Pin level model of the outside world wired to ports 0 to 2
`timescale 1ns/10ps
module pio_pins_model
  import pio_pkg::*;
(
  input wire pio_p0_drv_t p0_drv,
  input wire pio_p1_drv_t p1_drv,
  input wire pio_p2_drv_t p2_drv,
  input wire logic [7:0] p0_ext,
  input wire logic [4:0] p1_ext,
  input wire logic [2:0] p2_ext,
  output logic [7:0] p0_pin,
  output logic [4:0] p1_pin,
  output logic [2:0] p2_pin
);
  // A pin follows the port where enabled, else the outside driver
  assign p0_pin = (p0_drv.oe & p0_drv.o) | (~p0_drv.oe & p0_ext);
  assign p1_pin = (p1_drv.oe & p1_drv.o) | (~p1_drv.oe & p1_ext);
  assign p2_pin = (p2_drv.oe & p2_drv.o) | (~p2_drv.oe & p2_ext);
endmodule : pio_pins_model

// ===== rtl/pio_pkg.sv
// Parallel port block constants and carrier types
package pio_pkg;
  localparam int PIO_AW = 6;
  localparam logic [5:0] PIO_AREA_LAST = 6'h3F;
  localparam logic [5:0] PIO_OFS_P0_LATCH = 6'h00;
  localparam logic [5:0] PIO_OFS_P1_LATCH = 6'h01;
  localparam logic [5:0] PIO_OFS_P2_LATCH = 6'h02;
  localparam logic [5:0] PIO_OFS_P1_DIR = 6'h09;
  localparam logic [5:0] PIO_OFS_P0_DRIVE = 6'h0B;
  localparam logic [5:0] PIO_OFS_P0_PINS = 6'h0C;
  localparam logic [5:0] PIO_OFS_P2_PINS = 6'h0D;
  localparam logic [7:0] PIO_RST_P0_LATCH = 8'hFF;
  localparam logic [7:0] PIO_RST_P0_DRIVE = 8'h00;
  localparam logic [4:0] PIO_RST_P1_LATCH = 5'h00;
  localparam logic [4:0] PIO_RST_P1_DIR = 5'h00;
  localparam logic [2:0] PIO_RST_P2_LATCH = 3'h7;
  localparam int PIO_P1_INT_BIT = 0;
  localparam int PIO_P1_EDGE_BIT = 1;
  localparam int PIO_P2_INT_BIT = 0;
  // Enabled edges before the pin event detectors see real levels
  localparam logic [1:0] PIO_SYNC_FILL = 2'h3;
  // Upper fill of port 2 reads; those bits are undefined on the device
  localparam logic [4:0] PIO_P2_FILL = 5'h00;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } pio_p0_drv_t;

  typedef struct packed {
    logic [4:0] o;
    logic [4:0] oe;
  } pio_p1_drv_t;

  typedef struct packed {
    logic [2:0] o;
    logic [2:0] oe;
  } pio_p2_drv_t;

  typedef struct packed {
    logic p1_lo_fall;
    logic p1_edge;
    logic p2_lo_fall;
  } pio_evt_t;
endpackage : pio_pkg

// ===== rtl/pio_ports.sv
// Parallel ports 0 to 2 with their special function area registers
// Operation
// RULE1 - Decode registers within area 0000H to 003FH
// RULE2 - Software avoids reserved area locations
// RULE3 - No read-modify-write on write-only registers
// RULE4 - Outputs latched, inputs pass live pins; code reads pins through two-flop synchronisers and has no port1 pin read
// RULE5 - Pins sampled in read sample state
// RULE6 - Outputs change in write update state
// RULE7 - Reset: port0 latch ones, drive zeros
// RULE8 - Port0 per-bit open-drain or push-pull
// RULE9 - Port0 input: latch one, drive zero
// RULE10 - Port0 latch read, pin-read register
// RULE11 - Port1 five bits, direction, reset zero
// RULE12 - Set port1 latch before output mode
// RULE13 - Port1 bit one flags both edges
// RULE14 - Port1 bit zero port or interrupt
// RULE15 - Select bit: 0 port, 1 interrupt
// RULE16 - Port2 three bits, latch resets ones
// RULE17 - Dual clock: port2 upper pins resonator
// RULE18 - Port2 bit zero flags falling edges
// RULE19 - Port2 latch read, pin-read register
// RULE20 - Port2 read bits 7..3 undefined
// RULE21 - Stop mode floats port2 bit zero
// RULE22 - Drive bit 0 open-drain, 1 push-pull
// RULE23 - Direction 1 output, 0 input
`timescale 1ns/10ps
module pio_ports
  import pio_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [5:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic cpu_hit,
  input wire logic shared_pin_interrupt_select,
  input wire logic dual_clock_mode,
  input wire logic stop_mode,
  input wire logic [7:0] p0_in,
  output pio_p0_drv_t p0_drv,
  input wire logic [4:0] p1_in,
  output pio_p1_drv_t p1_drv,
  input wire logic [2:0] p2_in,
  output pio_p2_drv_t p2_drv,
  output pio_evt_t pin_evt
);

  function automatic logic [7:0] pio_p2_word(input logic [2:0] v);
    pio_p2_word = {PIO_P2_FILL, v};
  endfunction : pio_p2_word

  logic [7:0] p0_latch_r;
  logic [7:0] p0_drive_r;
  logic [4:0] p1_latch_r;
  logic [4:0] p1_dir_r;
  logic [2:0] p2_latch_r;
  logic [7:0] p0_s1_r;
  logic [7:0] p0_s2_r;
  logic [4:0] p1_s1_r;
  logic [4:0] p1_s2_r;
  logic [2:0] p2_s1_r;
  logic [2:0] p2_s2_r;
  logic [4:0] p1_old_r;
  logic [2:0] p2_old_r;
  logic wr_hit;
  logic [7:0] rdata_nxt;
  logic hit_nxt;
  logic [7:0] p0_oe_nxt;
  logic [4:0] p1_oe_nxt;
  logic [2:0] p2_oe_nxt;
  logic [1:0] sync_fill_r;
  logic sync_ready;

  // Two-flop synchronisers on the pins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      p0_s1_r <= 8'h00;
      p0_s2_r <= 8'h00;
      p1_s1_r <= 5'h00;
      p1_s2_r <= 5'h00;
      p2_s1_r <= 3'h0;
      p2_s2_r <= 3'h0;
      p1_old_r <= 5'h00;
      p2_old_r <= 3'h0;
    end else if (clk_en) begin
      p0_s1_r <= p0_in;
      p0_s2_r <= p0_s1_r;
      p1_s1_r <= p1_in;
      p1_s2_r <= p1_s1_r;
      p2_s1_r <= p2_in;
      p2_s2_r <= p2_s1_r;
      p1_old_r <= p1_s2_r;
      p2_old_r <= p2_s2_r;
    end
  end

  // RULE1 area decode
  assign wr_hit = cpu_wr && (cpu_addr <= PIO_AREA_LAST);

  // RULE7 RULE11 RULE16 latch reset; RULE6 RULE4 write update
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      p0_latch_r <= PIO_RST_P0_LATCH;
      p0_drive_r <= PIO_RST_P0_DRIVE;
      p1_latch_r <= PIO_RST_P1_LATCH;
      p1_dir_r <= PIO_RST_P1_DIR;
      p2_latch_r <= PIO_RST_P2_LATCH;
    end else if (clk_en && wr_hit) begin
      unique case (cpu_addr)
        PIO_OFS_P0_LATCH: p0_latch_r <= cpu_wdata;
        PIO_OFS_P0_DRIVE: p0_drive_r <= cpu_wdata;
        PIO_OFS_P1_LATCH: p1_latch_r <= cpu_wdata[4:0];
        PIO_OFS_P1_DIR: p1_dir_r <= cpu_wdata[4:0];
        PIO_OFS_P2_LATCH: p2_latch_r <= cpu_wdata[2:0];
        default: ;
      endcase
    end
  end

  // Read mux; pin reads return the two-flop synchronised levels, captured on the read cycle
  always_comb begin
    rdata_nxt = 8'h00;
    hit_nxt = 1'b1;
    unique case (cpu_addr)
      // RULE10 latch view
      PIO_OFS_P0_LATCH: rdata_nxt = p0_latch_r;
      PIO_OFS_P1_LATCH: rdata_nxt = {3'h0, p1_latch_r};
      // RULE19 RULE20 latch with undefined upper bits
      PIO_OFS_P2_LATCH: rdata_nxt = pio_p2_word(p2_latch_r);
      PIO_OFS_P1_DIR: rdata_nxt = {3'h0, p1_dir_r};
      PIO_OFS_P0_DRIVE: rdata_nxt = p0_drive_r;
      // RULE5 pin sample
      PIO_OFS_P0_PINS: rdata_nxt = p0_s2_r;
      PIO_OFS_P2_PINS: rdata_nxt = pio_p2_word(p2_s2_r);
      default: hit_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cpu_rdata <= 8'h00;
      cpu_hit <= 1'b0;
    end else if (clk_en) begin
      cpu_hit <= cpu_rd && hit_nxt;
      if (cpu_rd) begin
        cpu_rdata <= rdata_nxt;
      end
    end
  end

  // Output enables per port
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      // RULE8 RULE22 open-drain drives only low
      p0_oe_nxt[i] = p0_drive_r[i] | ~p0_latch_r[i];
    end
    // RULE23 direction
    p1_oe_nxt = p1_dir_r;
    // RULE14 RULE15 interrupt select keeps bit zero input
    if (shared_pin_interrupt_select) begin
      p1_oe_nxt[PIO_P1_INT_BIT] = 1'b0;
    end
    // Port 2 outputs are open-drain: drive low only
    p2_oe_nxt = ~p2_latch_r;
    // RULE17 resonator owns upper pins
    if (dual_clock_mode) begin
      p2_oe_nxt[2:1] = 2'b00;
    end
    // RULE21 stop floats bit zero
    if (stop_mode) begin
      p2_oe_nxt[PIO_P2_INT_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      p0_drv <= '{o: PIO_RST_P0_LATCH, oe: 8'h00};
      p1_drv <= '{o: PIO_RST_P1_LATCH, oe: 5'h00};
      p2_drv <= '{o: PIO_RST_P2_LATCH, oe: 3'h0};
    end else if (clk_en) begin
      p0_drv <= '{o: p0_latch_r, oe: p0_oe_nxt};
      p1_drv <= '{o: p1_latch_r, oe: p1_oe_nxt};
      p2_drv <= '{o: p2_latch_r, oe: p2_oe_nxt};
    end
  end

  // Edge detection stays off until synchronisers and old copy hold real
  // pin levels; their reset zeros would otherwise fake an edge
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync_fill_r <= 2'h0;
    end else if (clk_en && !sync_ready) begin
      sync_fill_r <= sync_fill_r + 2'h1;
    end
  end
  assign sync_ready = (sync_fill_r == PIO_SYNC_FILL);

  // Edge events for the interrupt latches, pulses
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_evt <= '0;
    end else if (clk_en) begin
      // RULE14 only when select is set
      pin_evt.p1_lo_fall <= sync_ready && shared_pin_interrupt_select &&
        p1_old_r[PIO_P1_INT_BIT] && !p1_s2_r[PIO_P1_INT_BIT];
      // RULE13 both edges even as output
      pin_evt.p1_edge <= sync_ready && (p1_old_r[PIO_P1_EDGE_BIT] ^
        p1_s2_r[PIO_P1_EDGE_BIT]);
      // RULE18 falling edge even as output
      pin_evt.p2_lo_fall <= sync_ready && p2_old_r[PIO_P2_INT_BIT] &&
        !p2_s2_r[PIO_P2_INT_BIT];
    end
  end

  // Assertions
  sequence s_wr_p0;
    clk_en && cpu_wr && cpu_addr == PIO_OFS_P0_LATCH;
  endsequence
  sequence s_wr_p1;
    clk_en && cpu_wr && cpu_addr == PIO_OFS_P1_LATCH;
  endsequence
  sequence s_rd_pins;
    clk_en && cpu_rd && cpu_addr == PIO_OFS_P0_PINS;
  endsequence
  sequence s_rd_p0;
    clk_en && cpu_rd && cpu_addr == PIO_OFS_P0_LATCH;
  endsequence
  sequence s_rd_p2;
    clk_en && cpu_rd && cpu_addr == PIO_OFS_P2_LATCH;
  endsequence
  sequence s_frozen;
    !clk_en;
  endsequence
  // Pin changes count only once the synchronisers are filled
  sequence s_p1_toggle;
    clk_en && sync_ready && (p1_old_r[1] != p1_s2_r[1]);
  endsequence
  sequence s_p2_fall;
    clk_en && sync_ready && p2_old_r[0] && !p2_s2_r[0];
  endsequence
  property p_rst_vals;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> (p0_latch_r == PIO_RST_P0_LATCH) &&
      (p0_drive_r == PIO_RST_P0_DRIVE);
  endproperty
  property p_rst_p1;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> (p1_latch_r == PIO_RST_P1_LATCH) &&
      (p1_dir_r == PIO_RST_P1_DIR);
  endproperty
  property p_rst_p2;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> p2_latch_r == PIO_RST_P2_LATCH;
  endproperty

  p0_reset_a: assert property (p_rst_vals) // RULE7
    else $error("port0 reset values wrong");
  p1_reset_a: assert property (p_rst_p1) // RULE11
    else $error("port1 reset values wrong");
  p2_reset_a: assert property (p_rst_p2) // RULE16
    else $error("port2 reset value wrong");
  p0_write_a: assert property ( // RULE6
    @(posedge clk_sys) disable iff (!rst_n)
    s_wr_p0 |=> p0_latch_r == $past(cpu_wdata))
    else $error("port0 latch not updated");
  p1_write_a: assert property ( // RULE6
    @(posedge clk_sys) disable iff (!rst_n)
    s_wr_p1 |=> {3'h0, p1_latch_r} == ($past(cpu_wdata) & 8'h1F))
    else $error("port1 latch not updated");
  p0_pinread_a: assert property ( // RULE5
    @(posedge clk_sys) disable iff (!rst_n)
    s_rd_pins |=> cpu_rdata == $past(p0_s2_r))
    else $error("port0 pin read wrong");
  p0_latchread_a: assert property ( // RULE10
    @(posedge clk_sys) disable iff (!rst_n)
    s_rd_p0 |=> cpu_rdata == $past(p0_latch_r))
    else $error("port0 latch read wrong");
  p2_latchread_a: assert property ( // RULE19
    @(posedge clk_sys) disable iff (!rst_n)
    s_rd_p2 |=> cpu_rdata[2:0] == $past(p2_latch_r))
    else $error("port2 latch read wrong");
  p2_upper_a: assert property ( // RULE20
    @(posedge clk_sys) disable iff (!rst_n)
    s_rd_p2 |=> cpu_rdata[7:3] == PIO_P2_FILL)
    else $error("port2 upper bits wrong");
  miss_hit_a: assert property ( // RULE1
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && cpu_rd && cpu_addr == PIO_AREA_LAST |=> !cpu_hit)
    else $error("unmapped read hit");
  map_hit_a: assert property ( // RULE1
    @(posedge clk_sys) disable iff (!rst_n)
    s_rd_p0 |=> cpu_hit)
    else $error("mapped read missed");
  p0_follow_a: assert property ( // RULE4
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en |=> p0_drv.o == $past(p0_latch_r))
    else $error("port0 drive not from latch");
  p0_odrain_a: assert property ( // RULE22
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && !p0_drive_r[0] && p0_latch_r[0] |=> !p0_drv.oe[0])
    else $error("open-drain drives high");
  p0_pushpull_a: assert property ( // RULE8
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && p0_drive_r[7] |=> p0_drv.oe[7])
    else $error("push-pull not driven");
  p1_dir_a: assert property ( // RULE23
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && !shared_pin_interrupt_select |=>
      p1_drv.oe == $past(p1_dir_r))
    else $error("port1 direction mismatch");
  p1_intsel_a: assert property ( // RULE15
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && shared_pin_interrupt_select |=> !p1_drv.oe[0])
    else $error("port1 bit zero driven");
  p1_nofall_a: assert property ( // RULE14
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && !shared_pin_interrupt_select |=> !pin_evt.p1_lo_fall)
    else $error("port1 bit zero event as port");
  p2_stop_a: assert property ( // RULE21
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && stop_mode |=> !p2_drv.oe[0])
    else $error("port2 bit zero driven in stop");
  p2_dual_a: assert property ( // RULE17
    @(posedge clk_sys) disable iff (!rst_n)
    clk_en && dual_clock_mode |=> p2_drv.oe[2:1] == 2'b00)
    else $error("resonator pins driven");
  p2_fall_a: assert property ( // RULE18
    @(posedge clk_sys) disable iff (!rst_n)
    s_p2_fall |=> pin_evt.p2_lo_fall)
    else $error("port2 fall missed");
  p1_edge_a: assert property ( // RULE13
    @(posedge clk_sys) disable iff (!rst_n)
    s_p1_toggle |=> pin_evt.p1_edge)
    else $error("port1 edge missed");
  latch_hold_a: assert property ( // RULE4
    @(posedge clk_sys) disable iff (!rst_n)
    s_frozen |=> $stable(p0_latch_r) && $stable(p1_latch_r) &&
      $stable(p2_latch_r) && $stable(p0_drive_r))
    else $error("latch moved while frozen");
  drive_hold_a: assert property ( // RULE4
    @(posedge clk_sys) disable iff (!rst_n)
    s_frozen |=> $stable(p0_drv) && $stable(p1_drv) &&
      $stable(p2_drv))
    else $error("pin drive moved while frozen");

endmodule : pio_ports
